/* tx_desc_defines.vh */
// constants for the transmit descriptor control word decoder
`ifndef TX_DESC_DEFINES_VH
`define TX_DESC_DEFINES_VH

// control word field positions
`define BIT_IRQ_REQ      31
`define BIT_FINAL_SEG    30
`define BIT_OPEN_SEG     29
`define BIT_FILT_HIGH    28
`define BIT_SETUP        27
`define BIT_CRC_INH      26
`define BIT_RING_WRAP    25
`define BIT_CHAINED      24
`define BIT_PAD_INH      23
`define BIT_FILT_LOW     22
`define LEN2_MSB         21
`define LEN2_LSB         11
`define LEN1_MSB         10
`define LEN1_LSB         0

// filter selector codes
`define FILT_PERFECT16   2'h0
`define FILT_HASH_PLUS1  2'h1
`define FILT_INVERSE     2'h2
`define FILT_HASH_ONLY   2'h3

// register offsets (byte addresses)
`define REG_STATUS       8'h00
`define REG_CLEAR        8'h04
`define REG_ENABLE       8'h08
`define REG_LIST_BASE    8'h0c
`define REG_CTRL_SHADOW  8'h10
`define REG_FRAME_STATE  8'h14

// status bit positions
`define ST_TX_IRQ        0
`define ST_SETUP_DONE    1
`define ST_SEQ_ERR       2
`define ST_WIDTH         3

// reset values
`define RST_ENABLE       3'h0
`define RST_LIST_BASE    32'h00000000

// descriptor size in bytes for sequential (unchained) stepping
`define DESC_STEP        32'h00000010

`endif

/* tx_descriptor_control_decode.v */
// transmit descriptor control word decoder and buffer sequencer
//
// Functional notes
// - completion flag set: raise tx interrupt status when the frame finishes
// - completion flag counts only with final segment or setup frame
// - final segment flag marks the descriptor ending the frame
// - opening segment flag marks the descriptor starting a new frame
// - filter selector is bit 28 high, bit 22 low
// - decode filter selector for setup frames only, four filtering modes
// - setup flag: buffer loads address filter, not transmitted
// - crc inhibit flag: no computed crc appended
// - crc inhibit sampled only from the opening segment descriptor
// - ring wrap: next descriptor comes from list base address
// - chained: second address word is next descriptor pointer
// - ring wrap and chained both set: ring wrap wins
// - pad inhibit: no padding for frames under 64 bytes
// - no pad inhibit and short frame: pad and crc, despite inhibit
// - bits 21:11 second buffer length, zero skips to next descriptor
// - chained descriptors ignore the second buffer length
// - bits 10:0 first buffer length, zero skips to second buffer
// - first buffer may start at any byte alignment
`default_nettype none
`include "tx_desc_defines.vh"

module tx_descriptor_control_decode (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_write_i,
  input  wire        reg_read_i,
  output reg  [31:0] reg_rdata_o,
  // descriptor fetch
  input  wire        desc_valid_i,
  input  wire [31:0] desc_addr_i,
  input  wire [31:0] tx_control_word_i,
  input  wire [31:0] first_buffer_addr_i,
  input  wire [31:0] second_addr_word_i,
  // transfer engine
  input  wire        xfer_done_i,
  output reg         xfer_req_o,
  output reg  [31:0] xfer_word_addr_o,
  output reg  [1:0]  xfer_byte_offset_o,
  output reg  [10:0] xfer_len_o,
  output reg         next_desc_req_o,
  output reg  [31:0] next_desc_addr_o,
  output reg         busy_o,
  // frame controls toward the transmitter
  input  wire        frame_done_i,
  input  wire        frame_short_i,
  output reg         frame_start_o,
  output reg         frame_end_o,
  output reg         setup_frame_o,
  output reg  [1:0]  filter_mode_o,
  output reg         filter_mode_valid_o,
  output reg         append_crc_o,
  output reg         add_pad_o,
  // interrupt
  output reg         irq_o
);

  // sequencer states: idle waits for a descriptor, each buffer state
  // issues at most one transfer, next hands the pointer on
  localparam S_IDLE = 2'h0;
  localparam S_BUF1 = 2'h1;
  localparam S_BUF2 = 2'h2;
  localparam S_NEXT = 2'h3;

  // state, latched descriptor and software registers
  reg [1:0]  state;
  reg [31:0] ctrl;          // latched control word
  reg [31:0] buf1_addr;
  reg [31:0] addr2;
  reg [31:0] cur_desc;
  reg [31:0] list_base;
  reg [2:0]  status;
  reg [2:0]  enable;
  // per-frame state, kept across the descriptors of one frame
  reg        in_frame;
  reg        frame_crc_inh; // crc inhibit held for the whole frame
  reg        frame_pad_inh;
  reg        irq_armed;     // completion interrupt pending for this frame
  reg        setup_armed;

  // decoded views of the latched word; only the fields that steer
  // the buffer walk are read back here, the frame flags act at fetch
  // time since the frame logic must see them in the accept cycle
  wire        f_wrap   = ctrl[`BIT_RING_WRAP];
  wire        f_chain  = ctrl[`BIT_CHAINED];
  wire [10:0] len1     = ctrl[`LEN1_MSB:`LEN1_LSB];
  wire [10:0] len2     = ctrl[`LEN2_MSB:`LEN2_LSB];

  // incoming word views, used at fetch
  // frame flags come straight from the bus so that frame start,
  // frame end and arming line up with the accept edge
  wire in_open  = tx_control_word_i[`BIT_OPEN_SEG];
  wire in_final = tx_control_word_i[`BIT_FINAL_SEG];
  wire in_setup = tx_control_word_i[`BIT_SETUP];
  wire in_irq   = tx_control_word_i[`BIT_IRQ_REQ];
  wire [1:0] in_filt = {tx_control_word_i[`BIT_FILT_HIGH],
                        tx_control_word_i[`BIT_FILT_LOW]};

  // buffer use decisions
  // a chained word has no second buffer, whatever its length field
  wire use_buf1 = (len1 != 11'h000);
  wire use_buf2 = ~f_chain & (len2 != 11'h000);

  // next descriptor address selection, wrap before chain
  // ring wrap is tested first so a wrapped chained descriptor
  // still returns to the list base
  reg [31:0] next_addr;
  always @* begin
    if (f_wrap) begin
      next_addr = list_base;
    end else if (f_chain) begin
      next_addr = addr2;
    end else begin
      next_addr = cur_desc + `DESC_STEP;
    end
  end

  // register write decode
  // writes to the status place or unmapped places fall through unseen
  wire wr_clear  = reg_write_i & (reg_addr_i == `REG_CLEAR);
  wire wr_enable = reg_write_i & (reg_addr_i == `REG_ENABLE);
  wire wr_base   = reg_write_i & (reg_addr_i == `REG_LIST_BASE);

  // events raised this cycle
  // sequence error: opening piece inside a frame, or a middle or
  // final piece with no frame open; a setup descriptor counts only when it is flagged as an opening piece inside a frame
  wire ev_irq   = frame_done_i & irq_armed;
  wire ev_setup = frame_done_i & setup_armed;
  wire ev_seq   = desc_valid_i & (state == S_IDLE) &
                  ((in_open & in_frame) | (~in_open & ~in_frame & ~in_setup));
  wire [2:0] ev = {ev_seq, ev_setup, ev_irq};

  // sticky status: a set in the clear cycle survives
  // the event is or-ed in after the clear mask, so software that
  // clears while a frame completes cannot lose the new event;
  // clear is write-one, zero bits of the word leave status alone
  always @(posedge clock_i) begin
    if (rst_i) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~(wr_clear ? reg_wdata_i[2:0] : 3'h0)) | ev;
    end
  end

  // software controls
  // list base takes any value; wrap jumps there without alignment
  always @(posedge clock_i) begin
    if (rst_i) begin
      enable    <= `RST_ENABLE;
      list_base <= `RST_LIST_BASE;
    end else begin
      if (wr_enable) begin
        enable <= reg_wdata_i[2:0];
      end
      if (wr_base) begin
        list_base <= reg_wdata_i;
      end
    end
  end

  // interrupt output, level while an enabled bit is set
  // built from next status and next enable, so irq_o, a flop,
  // changes on the same edge as the status it reflects;
  // a write to the enable place acts on that edge too
  always @(posedge clock_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((status & ~(wr_clear ? reg_wdata_i[2:0] : 3'h0)) | ev)
                 & (wr_enable ? reg_wdata_i[2:0] : enable));
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  // zero outside the answer cycle keeps a shared read mux quiet
  always @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `REG_STATUS:      reg_rdata_o <= {29'h0, status};
        `REG_ENABLE:      reg_rdata_o <= {29'h0, enable};
        `REG_LIST_BASE:   reg_rdata_o <= list_base;
        `REG_CTRL_SHADOW: reg_rdata_o <= ctrl;
        `REG_FRAME_STATE: reg_rdata_o <= {26'h0, state, setup_armed,
                                          irq_armed, frame_crc_inh, in_frame};
        default:          reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // descriptor latch and buffer sequencer
  // the whole word and both addresses are latched at accept, so the
  // host may reuse its fetch lines while buffers are still moving;
  // a zero length skips its buffer in a single cycle, which costs
  // one idle cycle per skipped buffer but keeps the walk uniform
  always @(posedge clock_i) begin
    if (rst_i) begin
      state              <= S_IDLE;
      ctrl               <= 32'h00000000;
      buf1_addr          <= 32'h00000000;
      addr2              <= 32'h00000000;
      cur_desc           <= 32'h00000000;
      xfer_req_o         <= 1'b0;
      xfer_word_addr_o   <= 32'h00000000;
      xfer_byte_offset_o <= 2'h0;
      xfer_len_o         <= 11'h000;
      next_desc_req_o    <= 1'b0;
      next_desc_addr_o   <= 32'h00000000;
      busy_o             <= 1'b0;
    end else begin
      next_desc_req_o <= 1'b0;
      case (state)
        S_IDLE: begin
          // descriptors offered while busy are never seen here
          if (desc_valid_i) begin
            ctrl      <= tx_control_word_i;
            buf1_addr <= first_buffer_addr_i;
            addr2     <= second_addr_word_i;
            cur_desc  <= desc_addr_i;
            busy_o    <= 1'b1;
            state     <= S_BUF1;
          end
        end
        S_BUF1: begin
          if (use_buf1 & ~xfer_req_o) begin
            // byte offset kept apart so any alignment is accepted
            xfer_req_o         <= 1'b1;
            xfer_word_addr_o   <= {buf1_addr[31:2], 2'h0};
            xfer_byte_offset_o <= buf1_addr[1:0];
            xfer_len_o         <= len1;
          end else if (xfer_req_o & xfer_done_i) begin
            xfer_req_o <= 1'b0;
            state      <= S_BUF2;
          end else if (~use_buf1) begin
            state <= S_BUF2;
          end
        end
        S_BUF2: begin
          // second buffer only for unchained words
          if (use_buf2 & ~xfer_req_o) begin
            xfer_req_o         <= 1'b1;
            xfer_word_addr_o   <= {addr2[31:2], 2'h0};
            xfer_byte_offset_o <= addr2[1:0];
            xfer_len_o         <= len2;
          end else if (xfer_req_o & xfer_done_i) begin
            xfer_req_o <= 1'b0;
            state      <= S_NEXT;
          end else if (~use_buf2) begin
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          // busy drops with the pulse, so a new descriptor may follow
          next_desc_req_o  <= 1'b1;
          next_desc_addr_o <= next_addr;
          busy_o           <= 1'b0;
          state            <= S_IDLE;
        end
        default: begin
          // unused code, recover to idle
          state <= S_IDLE;
        end
      endcase
    end
  end

  // frame boundaries and per-frame options
  // a descriptor accepted in the cycle of frame_done_i wins over the
  // disarm, since its flags belong to the next frame;
  // a single-piece frame sets and clears in_frame on one edge, and
  // the later assignment leaves it closed
  always @(posedge clock_i) begin
    if (rst_i) begin
      in_frame            <= 1'b0;
      frame_crc_inh       <= 1'b0;
      frame_pad_inh       <= 1'b0;
      irq_armed           <= 1'b0;
      setup_armed         <= 1'b0;
      frame_start_o       <= 1'b0;
      frame_end_o         <= 1'b0;
      setup_frame_o       <= 1'b0;
      filter_mode_o       <= `FILT_PERFECT16;
      filter_mode_valid_o <= 1'b0;
    end else begin
      frame_start_o <= 1'b0;
      frame_end_o   <= 1'b0;
      if (desc_valid_i & (state == S_IDLE)) begin
        setup_frame_o <= in_setup;
        if (in_setup) begin
          // filter mode only means something for setup frames
          filter_mode_o       <= in_filt;
          filter_mode_valid_o <= 1'b1;
          setup_armed         <= 1'b1;
          irq_armed           <= in_irq;
        end else begin
          filter_mode_valid_o <= 1'b0;
          if (in_open) begin
            in_frame      <= 1'b1;
            frame_start_o <= 1'b1;
            frame_crc_inh <= tx_control_word_i[`BIT_CRC_INH];
            frame_pad_inh <= tx_control_word_i[`BIT_PAD_INH];
          end
          if (in_final) begin
            in_frame    <= 1'b0;
            frame_end_o <= 1'b1;
            irq_armed   <= in_irq;
          end
        end
      end else if (frame_done_i) begin
        // completion seen: the armed event has been raised
        irq_armed   <= 1'b0;
        setup_armed <= 1'b0;
      end
    end
  end

  // crc and padding decision; a padded short frame always gets crc
  // inhibits come from the opening piece only, the short flag is live;
  // one cycle of lag keeps both outputs straight from flops, so the
  // transmitter must not sample them in the cycle it raises short
  always @(posedge clock_i) begin
    if (rst_i) begin
      // crc on by default, as for a descriptor with no inhibit
      append_crc_o <= 1'b1;
      add_pad_o    <= 1'b0;
    end else begin
      add_pad_o    <= ~frame_pad_inh & frame_short_i;
      append_crc_o <= ~frame_crc_inh |
                      (~frame_pad_inh & frame_short_i);
    end
  end

endmodule // tx_descriptor_control_decode
`default_nettype wire

/* tx_desc_checker.sv */
// port assertions and covers for the descriptor decoder
`default_nettype none
module tx_desc_checker (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // watched inputs
  input wire logic        desc_valid_i,
  input wire logic [31:0] tx_control_word_i,
  input wire logic        xfer_done_i,
  input wire logic        frame_short_i,
  // watched outputs
  input wire logic        busy_o,
  input wire logic        xfer_req_o,
  input wire logic [10:0] xfer_len_o,
  input wire logic        next_desc_req_o,
  input wire logic        frame_start_o,
  input wire logic        frame_end_o,
  input wire logic        setup_frame_o,
  input wire logic [1:0]  filter_mode_o,
  input wire logic        append_crc_o,
  input wire logic        add_pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // accept condition and the fields it carries
  wire        acc  = desc_valid_i && !busy_o;
  wire [31:0] w    = tx_control_word_i;
  wire [1:0]  fsel = {w[28], w[22]};
  wire [10:0] len1 = w[10:0];

  AST_BUSY: assert property (acc |=> busy_o)
    else $error("busy missing after accept");
  AST_START: assert property (acc && w[29] && !w[27] |=> frame_start_o)
    else $error("frame start pulse missing");
  AST_END: assert property (acc && w[30] && !w[27] |=> frame_end_o)
    else $error("frame end pulse missing");
  AST_SETUP: assert property (
    acc && w[27] |=> setup_frame_o && !frame_start_o)
    else $error("setup descriptor treated as frame");
  AST_FILTER: assert property (
    acc && w[27] |=> filter_mode_o == $past(fsel))
    else $error("filter mode differs from selector");
  AST_LEN1: assert property (
    acc && len1 != 0 |-> ##2 xfer_req_o && xfer_len_o == $past(len1, 2))
    else $error("first buffer request wrong");
  AST_SKIP: assert property (
    acc && w[21:0] == 0 |-> ##4 next_desc_req_o)
    else $error("empty descriptor not skipped");
  AST_HOLD: assert property (
    xfer_req_o && !xfer_done_i |=> xfer_req_o)
    else $error("transfer request dropped early");
  AST_PADCRC: assert property (
    add_pad_o |-> append_crc_o && $past(frame_short_i))
    else $error("padding without short frame or crc");
  // main scenarios reached
  cover property (acc && w[27]);
  cover property (xfer_req_o && xfer_done_i);
  cover property (add_pad_o);
endmodule // tx_desc_checker

bind tx_descriptor_control_decode tx_desc_checker u_tx_desc_checker (
  .clock_i(clock_i), .rst_i(rst_i), .desc_valid_i(desc_valid_i),
  .tx_control_word_i(tx_control_word_i), .xfer_done_i(xfer_done_i),
  .frame_short_i(frame_short_i), .busy_o(busy_o), .xfer_req_o(xfer_req_o),
  .xfer_len_o(xfer_len_o), .next_desc_req_o(next_desc_req_o),
  .frame_start_o(frame_start_o), .frame_end_o(frame_end_o),
  .setup_frame_o(setup_frame_o), .filter_mode_o(filter_mode_o),
  .append_crc_o(append_crc_o), .add_pad_o(add_pad_o));
`default_nettype wire

/* tx_host_model.sv */
// host side model: descriptor source and buffer transfer engine
`default_nettype none
module tx_host_model (
  // clock and decoder status
  input  wire logic        clock_i,
  input  wire logic        busy_i,
  input  wire logic        xfer_req_i,
  input  wire logic [3:0]  stall_i,
  // descriptor words and transfer completion
  output var  logic        desc_valid_o,
  output var  logic [31:0] desc_addr_o,
  output var  logic [31:0] cw_o,
  output var  logic [31:0] buf1_o,
  output var  logic [31:0] buf2_o,
  output var  logic        xfer_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // quiet bus at time zero
  initial begin
    desc_valid_o = 1'b0;
    xfer_done_o = 1'b0;
    wait_cnt = 4'h0;
    {desc_addr_o, cw_o, buf1_o, buf2_o} = '0;
  end
  // engine answers after stall_i cycles, only while the request stands
  always @(posedge clock_i) begin
    xfer_done_o <= 1'b0;
    if (xfer_req_i && !xfer_done_o) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= stall_i) begin
        xfer_done_o <= 1'b1;
        wait_cnt <= 4'h0;
      end
    end
  end
  // one descriptor handed over; words scrambled once it is taken
  task automatic post(input logic [31:0] c, d, b1, b2);
    while (busy_i) begin
      @(posedge clock_i);
      #1;
    end
    desc_valid_o <= 1'b1;
    {desc_addr_o, cw_o, buf1_o, buf2_o} <= {d, c, b1, b2};
    @(posedge clock_i);
    #1;
    desc_valid_o <= 1'b0;
    {desc_addr_o, cw_o, buf1_o, buf2_o} <= ~{d, c, b1, b2};
  endtask
endmodule // tx_host_model
`default_nettype wire

/* tx_descriptor_control_decode_test.sv */
// self-checking bench for the transmit descriptor decoder
`default_nettype none
module tx_descriptor_control_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 0, rst_i = 1, reg_write_i = 0, reg_read_i = 0;
  logic        frame_done_i = 0, frame_short_i = 0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, xfer_word_addr_o;
  logic [31:0] desc_addr_i, tx_control_word_i, next_desc_addr_o;
  logic [31:0] first_buffer_addr_i, second_addr_word_i;
  logic        desc_valid_i, xfer_done_i, xfer_req_o, next_desc_req_o;
  logic        busy_o, frame_start_o, frame_end_o, setup_frame_o, irq_o;
  logic        filter_mode_valid_o, append_crc_o, add_pad_o;
  logic [1:0]  xfer_byte_offset_o, filter_mode_o;
  logic [10:0] xfer_len_o;
  logic [3:0]  stall = 0;
  logic [31:0] base, c1, c2, da, b1, b2;
  logic        pad, crc;
  int          mismatches = 0, check_count = 0, cycles = 0;

  tx_descriptor_control_decode u_tx_descriptor_control_decode (.clock_i,
    .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
    .reg_rdata_o, .desc_valid_i, .desc_addr_i, .tx_control_word_i,
    .first_buffer_addr_i, .second_addr_word_i, .xfer_done_i, .xfer_req_o,
    .xfer_word_addr_o, .xfer_byte_offset_o, .xfer_len_o, .next_desc_req_o,
    .next_desc_addr_o, .busy_o, .frame_done_i, .frame_short_i,
    .frame_start_o, .frame_end_o, .setup_frame_o, .filter_mode_o,
    .filter_mode_valid_o, .append_crc_o, .add_pad_o, .irq_o);
  tx_host_model u_tx_host_model (.clock_i, .busy_i(busy_o),
    .xfer_req_i(xfer_req_o), .stall_i(stall), .desc_valid_o(desc_valid_i),
    .desc_addr_o(desc_addr_i), .cw_o(tx_control_word_i),
    .buf1_o(first_buffer_addr_i), .buf2_o(second_addr_word_i),
    .xfer_done_o(xfer_done_i));

  // 10 MHz clock and a hang guard well past the expected run
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait; a missing handshake counts as a mismatch
  task automatic await(ref logic s, input logic v);
    for (int n = 0; n < 200 && s !== v; n++) tick;
    chk("handshake", 1, s === v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_write_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    tick;
    reg_write_i <= 0;
    // let an edge pass so a following strobe is not assigned twice
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
    reg_read_i <= 1;
    reg_addr_i <= a;
    tick;
    reg_read_i <= 0;
    chk(n, e, reg_rdata_o);
    tick;
  endtask
  // expected next descriptor address: wrap beats chaining
  function automatic logic [31:0] nxt(input logic [31:0] c, d, s);
    if (c[25]) return base;
    if (c[24]) return s;
    return d + 32'h10;
  endfunction
  task automatic xfer(input logic [31:0] a, input logic [10:0] l);
    await(xfer_req_o, 1);
    chk("word address", a & ~32'h3, xfer_word_addr_o);
    chk("byte offset", a[1:0], xfer_byte_offset_o);
    chk("length", l, xfer_len_o);
    await(xfer_req_o, 0);
  endtask
  task automatic run(input logic [31:0] c);
    da = $urandom & 32'hffff_fff0;
    b1 = $urandom;
    b2 = $urandom;
    stall <= 4'($urandom_range(0, 5));
    u_tx_host_model.post(c, da, b1, b2);
    if (c[10:0] != 0) xfer(b1, c[10:0]);
    if (!c[24] && c[21:11] != 0) xfer(b2, c[21:11]);
    await(next_desc_req_o, 1);
    chk("next address", nxt(c, da, b2), next_desc_addr_o);
  endtask
  task automatic done_irq(input logic e, input logic [31:0] st);
    frame_done_i <= 1;
    tick;
    frame_done_i <= 0;
    tick;
    chk("interrupt", e, irq_o);
    rd(8'h00, st, "status");
    wr(8'h04, 32'h7);
    chk("interrupt cleared", 0, irq_o);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    base = $urandom(32'h8014d4a7);
    repeat (20) tick;
    rst_i <= 0;
    tick;
    // registers: reset value, read back, unmapped place
    rd(8'h08, 0, "enable at reset");
    base = $urandom & 32'hffff_fffc;
    wr(8'h0c, base);
    rd(8'h0c, base, "list base");
    rd(8'h40, 0, "unmapped");
    wr(8'h08, 32'h1);
    // setup frames in every filter mode, completion flag set
    for (int m = 0; m < 4; m++) begin
      c1 = 32'h8800_0001 | (m[1] << 28) | (m[0] << 22);
      run(c1 | ($urandom & 32'h033f_ffff));
      chk("filter mode", m, filter_mode_o);
      chk("setup level", 1, setup_frame_o);
      chk("filter valid", 1, filter_mode_valid_o);
      done_irq(1, 32'h3);
    end
    // two-piece frames; inhibits only from the opening piece
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, i & 1);
      frame_short_i <= 1'($urandom_range(0, 1));
      c1 = 32'ha000_0000 | ($urandom & 32'h07bf_ffff);
      if (i == 0) c1 = c1 & 32'hffc0_0000;
      if (i == 1) c1 = (c1 & 32'hfeff_f800) | 32'h800;
      run(c1);
      pad = !c1[23] && frame_short_i;
      crc = !c1[26] || pad;
      c2 = (i[1] ? 32'hc000_0000 : 32'h4000_0000) | (~c1 & 32'h0480_0000);
      run(c2 | ($urandom & 32'h033f_ffff));
      chk("pad", pad, add_pad_o);
      chk("crc", crc, append_crc_o);
      chk("setup level", 0, setup_frame_o);
      chk("filter valid", 0, filter_mode_valid_o);
      done_irq(i[0] & i[1], i[1]);
    end
    // final piece with no frame open: sequence error on its own enable
    wr(8'h08, 32'h4);
    run(32'h4000_0000);
    done_irq(1, 32'h4);
    rd(8'h10, 32'h4000_0000, "control shadow");
    report_and_stop;
  end
endmodule // tx_descriptor_control_decode_test
`default_nettype wire
